// >>> rtl/isp_cfg.svh
// Register indices, field positions, reset values and mode codes of the serial port.
// Included by the port top and its bound checker; holds only definitions.
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH

// Register indices; byte address is four times the index
`define ISP_IDX_LVL 8'h06
`define ISP_IDX_IRQ 8'h0c
`define ISP_IDX_BUF 8'h13
`define ISP_IDX_CTRL 8'h14
`define ISP_IDX_DIR 8'h86
`define ISP_IDX_ADDR 8'h93
`define ISP_IDX_STAT 8'h94

// Control register fields
`define ISP_CTRL_WCOL 7
`define ISP_CTRL_OVF 6
`define ISP_CTRL_EN 5
`define ISP_CTRL_REL 4

// Status register fields
`define ISP_STAT_SPH 7
`define ISP_STAT_EDG 6
`define ISP_STAT_DA 5
`define ISP_STAT_STOP 4
`define ISP_STAT_START 3
`define ISP_STAT_RW 2
`define ISP_STAT_UPD 1
`define ISP_STAT_FULL 0

// Direction register fields (1 = line released)
`define ISP_DIR_SCL 1
`define ISP_DIR_SDA 0

// Reset values
`define ISP_CTRL_RST 8'h00
`define ISP_MASK_RST 8'hff
`define ISP_ADDR_RST 8'h00
`define ISP_BUF_RST 8'h00
`define ISP_DIR_RST 2'h3

// Mode select codes
`define ISP_MODE_SLV7 4'h6
`define ISP_MODE_SLV10 4'h7
`define ISP_MODE_MASK 4'h9
`define ISP_MODE_FWM 4'hb
`define ISP_MODE_SLV7_SS 4'he
`define ISP_MODE_SLV10_SS 4'hf

`define ISP_BIT_LAST 4'h8
`define ISP_TX_LAST 4'h7

`endif

// >>> rtl/isp_pkg.sv
// Types shared by the serial port modules.
// Needs nothing from its surroundings.
package isp_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX_BITS,
      ST_ACK9,
      ST_TX_BITS,
      ST_TX_ACK9
   } isp_state_t;
endpackage : isp_pkg

// >>> rtl/isp_line_if.sv
// Synchronised bus line levels and events.
// Driven by the line synchroniser, read by the port core.
`timescale 1ns/10ps
interface isp_line_if;
   logic scl;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport src (output scl, output sda, output scl_rise, output scl_fall, output start,
      output stop);
   modport snk (input scl, input sda, input scl_rise, input scl_fall, input start,
      input stop);
endinterface : isp_line_if

// >>> rtl/isp_line_sync.sv
// Two-flop synchronisers for SCL and SDA plus edge, start and stop detection.
// Pins are asynchronous to clk; events are one-cycle pulses on clk.
`timescale 1ns/10ps
module isp_line_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_pin,
   input wire logic sda_pin,
   isp_line_if.src ln
);
   logic scl_m_r;
   logic scl_s_r;
   logic scl_d_r;
   logic sda_m_r;
   logic sda_s_r;
   logic sda_d_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_m_r <= scl_pin;
         scl_s_r <= scl_m_r;
         scl_d_r <= scl_s_r;
         sda_m_r <= sda_pin;
         sda_s_r <= sda_m_r;
         sda_d_r <= sda_s_r;
      end
   end

   assign ln.scl = scl_s_r;
   assign ln.sda = sda_s_r;
   assign ln.scl_rise = scl_s_r & ~scl_d_r;
   assign ln.scl_fall = ~scl_s_r & scl_d_r;
   // SDA edges while SCL stays high
   assign ln.start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
   assign ln.stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
endmodule : isp_line_sync

// >>> rtl/isp_addr_match.sv
// Masked comparison of a received address byte with the own address.
// Purely combinational; inputs come from the port core.
`timescale 1ns/10ps
module isp_addr_match #(
   parameter int W = 8
) (
   input wire logic [W-1:0] rx_byte,
   input wire logic [W-1:0] own_addr,
   input wire logic [W-1:0] mask,
   input wire logic ten_bit,
   output logic match
);
   logic [W-1:0] bit_ok;

   if (W < 2) begin : g_chk
      $error("isp_addr_match needs at least two address bits");
   end

   for (genvar i = 0; i < W; i++) begin : g_bit
      if (i == 0) begin : g_lsb
         assign bit_ok[i] = ~(ten_bit & mask[i]) | (rx_byte[i] == own_addr[i]);
      end else begin : g_hi
         assign bit_ok[i] = ~mask[i] | (rx_byte[i] == own_addr[i]);
      end
   end

   assign match = &bit_ok;
endmodule : isp_addr_match

// >>> rtl/isp_top.sv
// Serial port core: I2C slave with address mask, slave transmitter, clock
// stretching and start/stop flags for firmware mastering, behind classic Wishbone.
// Assumes open-drain pads with external pull-ups; CLOCK far faster than SCL.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
`include "isp_cfg.svh"
module isp_top
   import isp_pkg::*;
#(
   parameter int ADR_W = 10
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic [ADR_W-1:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   output logic WB_ACK_O,
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OE,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   output logic IRQ_FLAG
);
   if (ADR_W < 10) begin : g_chk
      $error("isp_top needs at least ten address bits");
   end

   isp_line_if ln ();

   isp_line_sync u_sync (
      .clk(CLOCK),
      .rst(RST),
      .scl_pin(SCL_IN),
      .sda_pin(SDA_IN),
      .ln(ln)
   );

   // Software-visible state
   logic [7:0] port_control_r;
   logic [7:0] port_control_nxt;
   logic [7:0] address_mask_r;
   logic [7:0] own_address_r;
   logic [7:0] data_buffer_r;
   logic [7:0] data_buffer_nxt;
   logic [1:0] pin_direction_r;
   logic sample_phase_r;
   logic edge_sel_r;
   logic data_addr_r;
   logic data_addr_nxt;
   logic start_seen_r;
   logic stop_seen_r;
   logic read_write_r;
   logic read_write_nxt;
   logic buffer_full_r;
   logic buffer_full_nxt;
   logic port_irq_r;

   // Link state
   isp_state_t state_r;
   isp_state_t state_nxt;
   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic addr_phase_r;
   logic addr_phase_nxt;
   logic ack_drv_r;
   logic ack_drv_nxt;
   logic ack_lat_r;
   logic ack_lat_nxt;
   logic stretch_r;
   logic stretch_nxt;
   logic byte_irq;
   logic ovf_set;
   logic wcol_set;
   logic rel_clr;

   // Bus slave and pad output state
   logic ack_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic scl_oe_r;
   logic sda_oe_r;
   logic scl_out_r;
   logic sda_out_r;

   // Bus decode
   wire [7:0] idx = WB_ADR_I[9:2];
   wire req = WB_CYC_I & WB_STB_I & ~ack_r;
   wire wr = req & WB_WE_I & WB_SEL_I[0];
   wire rd = req & ~WB_WE_I;
   wire [7:0] wdat = WB_DAT_I[7:0];
   wire hit_buf = idx == `ISP_IDX_BUF;
   wire hit_ctrl = idx == `ISP_IDX_CTRL;
   wire hit_addr = idx == `ISP_IDX_ADDR;
   wire hit_stat = idx == `ISP_IDX_STAT;
   wire hit_dir = idx == `ISP_IDX_DIR;
   wire hit_lvl = idx == `ISP_IDX_LVL;
   wire hit_irq = idx == `ISP_IDX_IRQ;

   // Mode decode
   wire [3:0] mode_select = port_control_r[3:0];
   wire port_enable = port_control_r[`ISP_CTRL_EN];
   wire clock_release = port_control_r[`ISP_CTRL_REL];
   wire rx_ovf = port_control_r[`ISP_CTRL_OVF];
   wire mask_alias = mode_select == `ISP_MODE_MASK;
   wire ten_bit = mode_select == `ISP_MODE_SLV10;
   wire slave_mode = (mode_select == `ISP_MODE_SLV7) | (mode_select == `ISP_MODE_SLV10) |
      (mode_select == `ISP_MODE_SLV7_SS) | (mode_select == `ISP_MODE_SLV10_SS);
   // Slave logic runs only in the four slave modes, not in firmware master mode
   wire slave_on = port_enable & slave_mode;
   wire edge_irq_mode = port_enable & ((mode_select == `ISP_MODE_FWM) |
      (mode_select == `ISP_MODE_SLV7_SS) | (mode_select == `ISP_MODE_SLV10_SS));

   // Register access strobes
   wire wr_buf = wr & hit_buf;
   wire rd_buf = rd & hit_buf;
   wire wr_ctrl = wr & hit_ctrl;
   wire wr_mask = wr & hit_addr & mask_alias;
   wire wr_own = wr & hit_addr & ~mask_alias;
   wire wr_stat = wr & hit_stat;
   wire wr_dir = wr & hit_dir;
   wire wr_irq = wr & hit_irq;

   logic addr_match;

   isp_addr_match #(
      .W(8)
   ) u_match (
      .rx_byte(shift_r),
      .own_addr(own_address_r),
      .mask(address_mask_r),
      .ten_bit(ten_bit),
      .match(addr_match)
   );

   // Byte engine
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      data_buffer_nxt = data_buffer_r;
      buffer_full_nxt = buffer_full_r;
      read_write_nxt = read_write_r;
      data_addr_nxt = data_addr_r;
      addr_phase_nxt = addr_phase_r;
      ack_drv_nxt = ack_drv_r;
      ack_lat_nxt = ack_lat_r;
      byte_irq = 1'b0;
      ovf_set = 1'b0;
      wcol_set = 1'b0;
      rel_clr = 1'b0;
      if (wr_buf) begin
         if (state_r == ST_TX_BITS && clock_release) begin
            wcol_set = 1'b1;
         end else begin
            data_buffer_nxt = wdat;
            shift_nxt = wdat;
            buffer_full_nxt = 1'b1;
         end
      end else if (rd_buf) begin
         buffer_full_nxt = 1'b0;
      end
      case (state_r)
         ST_IDLE: begin
         end
         ST_RX_BITS: begin
            if (ln.scl_rise && cnt_r != `ISP_BIT_LAST) begin
               shift_nxt = {shift_r[6:0], ln.sda};
               cnt_nxt = 4'(cnt_r + 4'h1);
            end else if (ln.scl_fall && cnt_r == `ISP_BIT_LAST) begin
               cnt_nxt = 4'h0;
               state_nxt = ST_ACK9;
               if (addr_phase_r && !addr_match) begin
                  state_nxt = ST_IDLE;
               end else if (!buffer_full_r && !rx_ovf) begin
                  data_buffer_nxt = shift_r;
                  buffer_full_nxt = 1'b1;
                  ack_drv_nxt = 1'b1;
                  data_addr_nxt = ~addr_phase_r;
                  if (addr_phase_r) begin
                     read_write_nxt = shift_r[0];
                  end
               end else begin
                  ack_drv_nxt = 1'b0;
                  ovf_set = buffer_full_r;
               end
            end
         end
         ST_ACK9: begin
            if (ln.scl_fall) begin
               byte_irq = 1'b1;
               ack_drv_nxt = 1'b0;
               addr_phase_nxt = 1'b0;
               if (addr_phase_r && !ack_drv_r) begin
                  state_nxt = ST_IDLE;
               end else if (addr_phase_r && read_write_r) begin
                  rel_clr = 1'b1;
                  state_nxt = ST_TX_BITS;
               end else begin
                  state_nxt = ST_RX_BITS;
               end
            end
         end
         ST_TX_BITS: begin
            if (ln.scl_fall) begin
               shift_nxt = {shift_r[6:0], 1'b1};
               if (cnt_r == `ISP_TX_LAST) begin
                  cnt_nxt = 4'h0;
                  buffer_full_nxt = 1'b0;
                  state_nxt = ST_TX_ACK9;
               end else begin
                  cnt_nxt = 4'(cnt_r + 4'h1);
               end
            end
         end
         ST_TX_ACK9: begin
            if (ln.scl_rise) begin
               ack_lat_nxt = ln.sda;
            end else if (ln.scl_fall) begin
               byte_irq = 1'b1;
               if (ack_lat_r) begin
                  state_nxt = ST_IDLE;
                  read_write_nxt = 1'b0;
                  data_addr_nxt = 1'b0;
                  buffer_full_nxt = 1'b0;
               end else begin
                  rel_clr = 1'b1;
                  data_addr_nxt = 1'b1;
                  state_nxt = ST_TX_BITS;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (!slave_on || ln.stop) begin
         state_nxt = ST_IDLE;
         ack_drv_nxt = 1'b0;
      end else if (ln.start) begin
         state_nxt = ST_RX_BITS;
         cnt_nxt = 4'h0;
         addr_phase_nxt = 1'b1;
         ack_drv_nxt = 1'b0;
      end
   end

   // Control register: software write, then hardware sets win
   always_comb begin
      port_control_nxt = wr_ctrl ? wdat : port_control_r;
      if (rel_clr && !wr_ctrl) begin
         port_control_nxt[`ISP_CTRL_REL] = 1'b0;
      end
      if (ovf_set) begin
         port_control_nxt[`ISP_CTRL_OVF] = 1'b1;
      end
      if (wcol_set) begin
         port_control_nxt[`ISP_CTRL_WCOL] = 1'b1;
      end
   end

   // Stretch only once SCL is seen low, hold until released
   assign stretch_nxt = slave_on & ~clock_release & (state_r == ST_TX_BITS) &
      (stretch_r | ~ln.scl);
   wire irq_set = byte_irq | (edge_irq_mode & (ln.start | ln.stop));
   wire fw_scl_low = port_enable & ~pin_direction_r[`ISP_DIR_SCL];
   wire fw_sda_low = port_enable & ~pin_direction_r[`ISP_DIR_SDA];
   wire sda_drv = ((state_r == ST_ACK9) & ack_drv_r) |
      ((state_r == ST_TX_BITS) & ~shift_r[7]) | fw_sda_low;
   wire [7:0] status_rd = {sample_phase_r, edge_sel_r, data_addr_r, stop_seen_r,
      start_seen_r, read_write_r, 1'b0, buffer_full_r};

   always_comb begin
      rdata_nxt = 32'h0;
      if (hit_buf) begin
         rdata_nxt[7:0] = data_buffer_r;
      end else if (hit_ctrl) begin
         rdata_nxt[7:0] = port_control_r;
      end else if (hit_addr) begin
         rdata_nxt[7:0] = mask_alias ? address_mask_r : own_address_r;
      end else if (hit_stat) begin
         rdata_nxt[7:0] = status_rd;
      end else if (hit_dir) begin
         rdata_nxt[7:0] = {1'b0, pin_direction_r[`ISP_DIR_SCL], 1'b0,
            pin_direction_r[`ISP_DIR_SDA], 4'h0};
      end else if (hit_lvl) begin
         rdata_nxt[7:0] = {1'b0, ln.scl, 1'b0, ln.sda, 4'h0};
      end else if (hit_irq) begin
         rdata_nxt[7:0] = {7'h0, port_irq_r};
      end
   end

   // Bus slave
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ack_r <= 1'b0;
         rdata_r <= 32'h0;
      end else begin
         ack_r <= req;
         if (rd) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   // Registers
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         port_control_r <= `ISP_CTRL_RST;
         address_mask_r <= `ISP_MASK_RST;
         own_address_r <= `ISP_ADDR_RST;
         pin_direction_r <= `ISP_DIR_RST;
         sample_phase_r <= 1'b0;
         edge_sel_r <= 1'b0;
         port_irq_r <= 1'b0;
      end else begin
         port_control_r <= port_control_nxt;
         if (wr_mask) begin
            address_mask_r <= wdat;
         end
         if (wr_own) begin
            own_address_r <= wdat;
         end
         if (wr_dir) begin
            pin_direction_r <= {wdat[6], wdat[4]};
         end
         if (wr_stat) begin
            sample_phase_r <= wdat[`ISP_STAT_SPH];
            edge_sel_r <= wdat[`ISP_STAT_EDG];
         end
         port_irq_r <= irq_set | (wr_irq ? wdat[0] : port_irq_r);
      end
   end

   // Start and stop flags
   always_ff @(posedge CLOCK) begin
      if (RST || !port_enable) begin
         start_seen_r <= 1'b0;
         stop_seen_r <= 1'b0;
      end else if (ln.start) begin
         start_seen_r <= 1'b1;
         stop_seen_r <= 1'b0;
      end else if (ln.stop) begin
         start_seen_r <= 1'b0;
         stop_seen_r <= 1'b1;
      end
   end

   // Link state
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         shift_r <= 8'hff;
         data_buffer_r <= `ISP_BUF_RST;
         buffer_full_r <= 1'b0;
         read_write_r <= 1'b0;
         data_addr_r <= 1'b0;
         addr_phase_r <= 1'b0;
         ack_drv_r <= 1'b0;
         ack_lat_r <= 1'b1;
         stretch_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         data_buffer_r <= data_buffer_nxt;
         buffer_full_r <= buffer_full_nxt;
         read_write_r <= read_write_nxt;
         data_addr_r <= data_addr_nxt;
         addr_phase_r <= addr_phase_nxt;
         ack_drv_r <= ack_drv_nxt;
         ack_lat_r <= ack_lat_nxt;
         stretch_r <= stretch_nxt;
      end
   end

   // Pads: outputs always low, enable pulls the line
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         scl_out_r <= 1'b0;
         sda_out_r <= 1'b0;
      end else begin
         scl_oe_r <= stretch_nxt | fw_scl_low;
         sda_oe_r <= sda_drv;
         scl_out_r <= 1'b0;
         sda_out_r <= 1'b0;
      end
   end

   assign WB_ACK_O = ack_r;
   assign WB_DAT_O = rdata_r;
   assign SCL_OE = scl_oe_r;
   assign SDA_OE = sda_oe_r;
   assign SCL_OUT = scl_out_r;
   assign SDA_OUT = sda_out_r;
   assign IRQ_FLAG = port_irq_r;
endmodule : isp_top

// >>> bench/isp_top_asserts.sv
// Checker for the serial port top: bus handshake, line drive and stretching.
// Sees only the top ports; bound into every isp_top instance.
`timescale 1ns/10ps
`include "isp_cfg.svh"
module isp_top_asserts #(
   parameter int ADR_W = 10
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic [ADR_W-1:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_ACK_O,
   input wire logic SCL_IN,
   input wire logic SCL_OUT,
   input wire logic SCL_OE,
   input wire logic SDA_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic IRQ_FLAG
);
   logic [3:0] hi_cnt_r;
   logic wr_hit;
   logic rel_wr;
   logic irq_wr;
   assign wr_hit = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && !WB_ACK_O;
   assign rel_wr = wr_hit && WB_ADR_I[9:2] == `ISP_IDX_CTRL && WB_DAT_I[`ISP_CTRL_REL];
   assign irq_wr = wr_hit && WB_ADR_I[9:2] == `ISP_IDX_IRQ && !WB_DAT_I[0];
   // Cycles of SCL seen high in a row
   always_ff @(posedge CLOCK) begin
      if (RST || !SCL_IN) begin
         hi_cnt_r <= 4'h0;
      end else if (hi_cnt_r != 4'hf) begin
         hi_cnt_r <= hi_cnt_r + 4'h1;
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   a_ack_follows_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack missing after request");
   a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without request");
   a_read_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_sda_stable_high: assert property (hi_cnt_r >= 4'h6 |-> $stable(SDA_OE))
      else $error("data line moved while clock high");
   // Clock level at the edge that launched the new drive
   a_sda_rise_low: assert property ($rose(SDA_OE) |->
      !$past(SCL_IN) && !$past(SCL_IN, 2))
      else $error("data drive started with clock high");
   a_stretch_after_low: assert property ($rose(SCL_OE) |->
      !$past(SCL_IN) && !$past(SCL_IN, 3))
      else $error("stretch began before clock seen low");
   a_stretch_hold: assert property ($fell(SCL_OE) |->
      $past(rel_wr) || $past(rel_wr, 2) || $past(rel_wr, 3))
      else $error("clock released without release bit");
   a_irq_sw_clear: assert property ($fell(IRQ_FLAG) |->
      $past(irq_wr) || $past(irq_wr, 2) || $past(irq_wr, 3))
      else $error("irq flag cleared by hardware");
   a_out_zero: assert property (!SCL_OUT && !SDA_OUT)
      else $error("line output value not low");
endmodule : isp_top_asserts

bind isp_top isp_top_asserts #(.ADR_W(ADR_W)) isp_top_asserts_i (
   .CLOCK(CLOCK), .RST(RST), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O), .WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT),
   .SCL_OE(SCL_OE), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
   .IRQ_FLAG(IRQ_FLAG)
);

// >>> bench/isp_i2c_master.sv
// Behavioural I2C master on the far side: start, stop and byte transfers.
// Open-drain, moving off the falling clk edge; the bench folds enables into line levels.
`timescale 1ns/10ps
module isp_i2c_master (
   input wire logic clk,
   input wire logic scl_w,
   input wire logic sda_w,
   output logic scl_oe,
   output logic sda_oe
);
   int stuck = 0;
   int lost = 0;
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
   // Releases clock, waits out a stretch of up to 2000 polls of 40 ns, keeps high time
   task automatic clk_high();
      int k;
      k = 0;
      scl_oe = 1'b0;
      while (!scl_w && k < 2000) begin
         #40;
         k++;
      end
      if (!scl_w) stuck++;
      #160;
   endtask : clk_high
   task automatic start();
      @(negedge clk);
      #160 sda_oe = 1'b1;
      #160 scl_oe = 1'b1;
   endtask : start
   task automatic stop();
      @(negedge clk);
      #40 sda_oe = 1'b1;
      #120 clk_high();
      sda_oe = 1'b0;
      #160;
   endtask : stop
   // Eight bits MSB first, then the ninth (acknowledge) clock
   task automatic xfer(input logic [7:0] d, input logic ackb, output logic [7:0] q,
      output logic a);
      logic [8:0] v;
      logic [8:0] r;
      v = {d, ackb};
      @(negedge clk);
      for (int i = 8; i >= 0; i--) begin
         #40 sda_oe = !v[i];
         #120 clk_high();
         r[i] = sda_w;
         // Sending high, reading low: lost, both lines left released
         if (i > 0 && d != 8'hff && v[i] && !r[i]) begin
            lost++;
            break;
         end
         scl_oe = 1'b1;
      end
      q = r[8:1];
      a = r[0];
   endtask : xfer
endmodule : isp_i2c_master

// >>> bench/test_isp_top.sv
// Self-checking bench: register access, address mask, firmware master flags
// and slave transmit against a behavioural master; pull-ups on both lines.
`timescale 1ns/10ps
module test_isp_top;
   localparam logic [9:0] A_BUF = 10'h04c, A_CTL = 10'h050, A_OWN = 10'h24c;
   localparam logic [9:0] A_STA = 10'h250, A_IRQ = 10'h030;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [9:0] adr = 10'h000;
   logic [31:0] dat_i = 32'h0;
   logic we = 1'b0;
   logic [3:0] sel = 4'hf;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [31:0] dat_o;
   logic ack, scl_oe, scl_out, sda_oe, sda_out, irq, m_scl_oe, m_sda_oe;
   wire scl_w = !(scl_oe || m_scl_oe);
   wire sda_w = !(sda_oe || m_sda_oe);
   int bad_count = 0;
   int cmp_count = 0;
   // mode, mask, own address, address byte, acknowledge expected
   logic [31:0] cases [5] = '{32'h6fca0a21, 32'h6fca0a40, 32'h6ffa1a01, 32'h7ffa1a00,
      32'h7fea1a01};
   always #20 clk = ~clk;
   isp_top isp_top_i (
      .CLOCK(clk), .RST(rst), .WB_ADR_I(adr), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
      .WB_WE_I(we), .WB_SEL_I(sel), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
      .SCL_IN(scl_w), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda_w),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .IRQ_FLAG(irq)
   );
   isp_i2c_master isp_i2c_master_i (.clk(clk), .scl_w(scl_w), .sda_w(sda_w),
      .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
   task automatic wrap_up();
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // One classic Wishbone cycle; read data taken at the ack edge
   task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d,
      output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         bad_count++;
         wrap_up();
      end
   endtask : wb
   initial begin
      logic [7:0] q;
      logic a;
      logic [31:0] c;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      wb(1'b0, A_CTL, 8'h00, q);
      check(q, 8'h00);
      wb(1'b0, A_STA, 8'h00, q);
      check(q, 8'h00);
      wb(1'b1, A_CTL, 8'h09, q);
      wb(1'b0, A_OWN, 8'h00, q);
      check(q, 8'hff);
      wb(1'b1, A_CTL, 8'h06, q);
      wb(1'b0, A_OWN, 8'h00, q);
      check(q, 8'h00);
      wb(1'b0, 10'h3fc, 8'h00, q);
      check(q, 8'h00);
      wb(1'b0, 10'h018, 8'h00, q);
      check(q, 8'h50);
      wb(1'b0, 10'h218, 8'h00, q);
      check(q, 8'h50);
      foreach (cases[i]) begin
         c = cases[i];
         wb(1'b1, A_CTL, 8'h09, q);
         wb(1'b1, A_OWN, c[27:20], q);
         wb(1'b1, A_CTL, {4'h3, c[31:28]}, q);
         wb(1'b1, A_OWN, c[19:12], q);
         isp_i2c_master_i.start();
         isp_i2c_master_i.xfer(c[11:4], 1'b1, q, a);
         isp_i2c_master_i.stop();
         check(!a, c[0]);
         check(irq, c[0]);
         wb(1'b0, A_STA, 8'h00, q);
         check(q & 8'h18, 8'h10);
         wb(1'b0, A_BUF, 8'h00, q);
         wb(1'b1, A_IRQ, 8'h00, q);
      end
      wb(1'b1, A_CTL, 8'h00, q);
      wb(1'b0, A_STA, 8'h00, q);
      check(q & 8'h18, 8'h00);
      wb(1'b1, A_CTL, 8'h2b, q);
      isp_i2c_master_i.start();
      repeat (8) @(posedge clk);
      check(irq, 1'b1);
      wb(1'b1, A_IRQ, 8'h00, q);
      isp_i2c_master_i.stop();
      repeat (8) @(posedge clk);
      check(irq, 1'b1);
      wb(1'b1, A_IRQ, 8'h00, q);
      wb(1'b1, A_CTL, 8'h09, q);
      wb(1'b1, A_OWN, 8'hff, q);
      wb(1'b1, A_CTL, 8'h36, q);
      wb(1'b1, A_OWN, 8'ha0, q);
      isp_i2c_master_i.start();
      isp_i2c_master_i.xfer(8'ha1, 1'b1, q, a);
      check(a, 1'b0);
      repeat (10) @(posedge clk);
      check(scl_oe, 1'b1);
      check(irq, 1'b1);
      wb(1'b0, A_STA, 8'h00, q);
      check(q & 8'h05, 8'h05);
      wb(1'b0, A_BUF, 8'h00, q);
      check(q, 8'ha1);
      wb(1'b1, A_IRQ, 8'h00, q);
      wb(1'b1, A_BUF, 8'h5a, q);
      wb(1'b1, A_CTL, 8'h36, q);
      isp_i2c_master_i.xfer(8'hff, 1'b0, q, a);
      check(q, 8'h5a);
      repeat (10) @(posedge clk);
      check(scl_oe, 1'b1);
      check(irq, 1'b1);
      wb(1'b1, A_IRQ, 8'h00, q);
      wb(1'b1, A_BUF, 8'hc3, q);
      wb(1'b1, A_CTL, 8'h36, q);
      isp_i2c_master_i.xfer(8'hff, 1'b1, q, a);
      check(q, 8'hc3);
      isp_i2c_master_i.stop();
      wb(1'b0, A_STA, 8'h00, q);
      check(q & 8'h07, 8'h00);
      check(isp_i2c_master_i.stuck, 0);
      check(isp_i2c_master_i.lost, 0);
      // Mid-run resets: first with stop flag and irq set, then with a mask written
      for (int k = 0; k < 2; k++) begin
         rst <= 1'b1;
         repeat (2) @(posedge clk);
         rst <= 1'b0;
         wb(1'b0, A_STA, 8'h00, q);
         check(q, 8'h00);
         check(irq, 1'b0);
         wb(1'b1, A_CTL, 8'h09, q);
         wb(1'b0, A_OWN, 8'h00, q);
         check(q, 8'hff);
         wb(1'b1, A_OWN, 8'h3c, q);
      end
      wrap_up();
   end
endmodule : test_isp_top
